// [hdl/psq_slot_seq.sv]
// Slot sequencer with configuration registers, a fault timeout on power-up only, and recovery
`timescale 1ns/1ps
module psq_slot_seq
    import psq_pkg::*;
#(
    parameter int CLK_MHZ_P = CLK_MHZ,
    parameter int US_DIV = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Sequencing control
    input wire logic seq_enable,
    input wire logic [NUM_SLOTS-1:0] monitored_voltage_input,
    input wire logic conversion_done,
    input wire logic fault_raw,
    // Outputs
    output logic [NUM_OUTS-1:0] en_out,
    output logic [3:0] tracking_pulldown_en,
    output logic [1:0] slew_select,
    output logic fault_active,
    output logic power_on
);
    typedef struct packed {
        logic [7:0] cfg_flt;
        logic [7:0] cfg_retry;
        logic [7:0] dly_a;
        logic [7:0] dly_b;
        logic [7:0] dly_c;
        logic [7:0] dly_d;
        logic [7:0] dly_e;
        logic [NUM_OUTS*4-1:0] assign_cfg;
        psq_state_t state;
        logic [3:0] slot;
        logic waiting;
        logic [CNT_W-1:0] dly_cnt;
        logic [CNT_W-1:0] flt_cnt;
        logic [4:0] glitch_cnt;
        logic [7:0] rdata;
        logic [NUM_OUTS-1:0] en;
        logic [3:0] pd;
        logic [1:0] slew;
        logic fault;
        logic on;
    } psq_regs_t;

    psq_regs_t cur, next_cur;

    function automatic logic [2:0] slot_delay_code(input psq_regs_t r, input logic [3:0] s);
        logic [2:0] c;
        c = 3'h0;
        case (s)
            4'h0: c = r.dly_a[2:0];
            4'h1: c = r.dly_a[5:3];
            4'h2: c = {r.dly_b[0], r.dly_a[7:6]};
            4'h3: c = r.dly_b[3:1];
            4'h4: c = r.dly_b[6:4];
            4'h5: c = {r.dly_c[1:0], r.dly_b[7]};
            4'h6: c = r.dly_c[4:2];
            4'h7: c = r.dly_c[7:5];
            4'h8: c = r.dly_d[2:0];
            4'h9: c = r.dly_d[5:3];
            4'ha: c = {r.dly_e[0], r.dly_d[7:6]};
            4'hb: c = r.dly_e[3:1];
            default: c = 3'h0;
        endcase
        return c;
    endfunction

    // Cycle count of a delay code, also used for autoretry
    function automatic logic [CNT_W-1:0] delay_cycles(input logic [2:0] c);
        return CNT_W'(DLY_US_X10[c] * CLK_MHZ_P / (10 * US_DIV));
    endfunction

    function automatic logic [CNT_W-1:0] fault_cycles(input logic [1:0] c);
        return CNT_W'(FLT_MS[c] * 1000 * CLK_MHZ_P / US_DIV);
    endfunction

    // Outputs assigned to a given slot
    function automatic logic [NUM_OUTS-1:0] slot_mask(input psq_regs_t r, input logic [3:0] s);
        logic [NUM_OUTS-1:0] m;
        logic [3:0] code;
        m = '0;
        for (int i = 0; i < NUM_OUTS; i++) begin
            code = r.assign_cfg[i*4 +: 4];
            if (code != CODE_NONE && code <= CODE_MAX && (code - 4'h1) == s) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    always_comb begin
        logic [7:0] idx;
        logic glitch_hit;
        idx = reg_addr - ADDR_ASSIGN_BASE;
        glitch_hit = 1'b0;
        next_cur = cur;
        // Register writes
        if (reg_wr) begin
            if (reg_addr == ADDR_FLT_TMO) begin
                next_cur.cfg_flt = reg_wdata;
            end else if (reg_addr == ADDR_RETRY) begin
                next_cur.cfg_retry = reg_wdata;
            end else if (reg_addr == ADDR_DLY_A) begin
                next_cur.dly_a = reg_wdata;
            end else if (reg_addr == ADDR_DLY_B) begin
                next_cur.dly_b = reg_wdata;
            end else if (reg_addr == ADDR_DLY_C) begin
                next_cur.dly_c = reg_wdata;
            end else if (reg_addr == ADDR_DLY_D) begin
                next_cur.dly_d = reg_wdata;
            end else if (reg_addr == ADDR_DLY_E) begin
                next_cur.dly_e = reg_wdata & DLY_E_RW_MASK;
            end else if (idx < 8'(NUM_OUTS / 2)) begin
                next_cur.assign_cfg[idx[2:0]*8 +: 8] = reg_wdata;
            end
        end
        // Register reads
        if (reg_rd) begin
            if (reg_addr == ADDR_FLT_TMO) begin
                next_cur.rdata = cur.cfg_flt;
            end else if (reg_addr == ADDR_RETRY) begin
                next_cur.rdata = cur.cfg_retry;
            end else if (reg_addr == ADDR_DLY_A) begin
                next_cur.rdata = cur.dly_a;
            end else if (reg_addr == ADDR_DLY_B) begin
                next_cur.rdata = cur.dly_b;
            end else if (reg_addr == ADDR_DLY_C) begin
                next_cur.rdata = cur.dly_c;
            end else if (reg_addr == ADDR_DLY_D) begin
                next_cur.rdata = cur.dly_d;
            end else if (reg_addr == ADDR_DLY_E) begin
                next_cur.rdata = cur.dly_e;
            end else if (idx < 8'(NUM_OUTS / 2)) begin
                next_cur.rdata = cur.assign_cfg[idx[2:0]*8 +: 8];
            end else begin
                next_cur.rdata = 8'h00;
            end
        end
        next_cur.pd = cur.cfg_flt[7:4];
        next_cur.slew = cur.cfg_retry[5:4];
        // Fault deglitch over conversions
        if (conversion_done) begin
            if (fault_raw) begin
                if (5'(cur.glitch_cnt + 5'h1) >= 5'(DEGLITCH[cur.cfg_retry[7:6]])) begin
                    glitch_hit = 1'b1;
                end else begin
                    next_cur.glitch_cnt = cur.glitch_cnt + 5'h1;
                end
            end else begin
                next_cur.glitch_cnt = 5'h0;
            end
        end
        if (cur.dly_cnt != '0) begin
            next_cur.dly_cnt = cur.dly_cnt - 1'b1;
        end
        if (cur.flt_cnt != '0) begin
            next_cur.flt_cnt = cur.flt_cnt - 1'b1;
        end
        case (cur.state)
            PSQ_OFF: begin
                next_cur.on = 1'b0;
                if (seq_enable) begin
                    next_cur.state = PSQ_UP;
                    next_cur.slot = 4'h0;
                    next_cur.waiting = 1'b0;
                    next_cur.flt_cnt = fault_cycles(cur.cfg_flt[1:0]);
                end
            end
            PSQ_UP: begin
                if (!seq_enable) begin
                    next_cur.state = PSQ_DOWN;
                end else if (!cur.waiting) begin
                    if (cur.slot == 4'h0 || monitored_voltage_input[cur.slot - 4'h1]) begin
                        next_cur.en = cur.en | slot_mask(cur, cur.slot);
                        next_cur.dly_cnt = delay_cycles(slot_delay_code(cur, cur.slot));
                        next_cur.waiting = 1'b1;
                    end else if (cur.flt_cnt == '0) begin
                        next_cur.fault = 1'b1;
                    end
                end else if (cur.dly_cnt == '0) begin
                    next_cur.waiting = 1'b0;
                    next_cur.flt_cnt = fault_cycles(cur.cfg_flt[1:0]);
                    if (cur.slot == 4'(NUM_SLOTS - 1)) begin
                        next_cur.state = PSQ_ON;
                    end else begin
                        next_cur.slot = cur.slot + 4'h1;
                    end
                end
            end
            PSQ_ON: begin
                next_cur.on = 1'b1;
                if (!seq_enable) begin
                    next_cur.state = PSQ_DOWN;
                end
            end
            PSQ_DOWN: begin
                next_cur.on = 1'b0;
                if (!cur.dly_e[BIT_REVERSE]) begin
                    next_cur.en = '0;
                    next_cur.state = PSQ_OFF;
                end else if (!cur.waiting) begin
                    next_cur.en = cur.en & ~slot_mask(cur, cur.slot);
                    next_cur.dly_cnt = delay_cycles(slot_delay_code(cur, cur.slot));
                    next_cur.flt_cnt = fault_cycles(cur.cfg_flt[3:2]);
                    next_cur.waiting = 1'b1;
                end else if (cur.dly_cnt == '0) begin
                    next_cur.waiting = 1'b0;
                    if (cur.slot == 4'h0) begin
                        next_cur.state = PSQ_OFF;
                    end else begin
                        next_cur.slot = cur.slot - 4'h1;
                    end
                end
            end
            PSQ_RETRY: begin
                if (cur.dly_cnt == '0) begin
                    next_cur.fault = 1'b0;
                    next_cur.state = PSQ_OFF;
                end
            end
            default: begin
                next_cur.en = '0;
            end
        endcase
        if (glitch_hit) begin
            next_cur.fault = 1'b1;
        end
        // Fault handling
        if (next_cur.fault && cur.state != PSQ_RETRY && cur.state != PSQ_LATCH) begin
            next_cur.en = '0;
            next_cur.on = 1'b0;
            next_cur.waiting = 1'b0;
            next_cur.glitch_cnt = 5'h0;
            if (cur.cfg_retry[BIT_RECOVERY]) begin
                next_cur.state = PSQ_LATCH;
            end else begin
                next_cur.state = PSQ_RETRY;
                next_cur.dly_cnt = delay_cycles(cur.cfg_retry[2:0]);
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cur <= '0;
            cur.state <= PSQ_OFF;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata = cur.rdata;
    assign en_out = cur.en;
    assign tracking_pulldown_en = cur.pd;
    assign slew_select = cur.slew;
    assign fault_active = cur.fault;
    assign power_on = cur.on;
endmodule

// [hdl/psq_pkg.sv]
// Package of register map, field layout and timing constants for the slot sequencer
package psq_pkg;
    localparam int CLK_MHZ = 250;
    localparam logic [7:0] ADDR_FLT_TMO = 8'h4e;
    localparam logic [7:0] ADDR_RETRY = 8'h4f;
    localparam logic [7:0] ADDR_DLY_A = 8'h50;
    localparam logic [7:0] ADDR_DLY_B = 8'h51;
    localparam logic [7:0] ADDR_DLY_C = 8'h52;
    localparam logic [7:0] ADDR_DLY_D = 8'h53;
    localparam logic [7:0] ADDR_DLY_E = 8'h54;
    localparam logic [7:0] ADDR_ASSIGN_BASE = 8'h5e;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] DLY_E_RW_MASK = 8'h1f;
    localparam int NUM_SLOTS = 12;
    localparam int NUM_OUTS = 12;
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_MAX = 4'hc;
    localparam int BIT_RECOVERY = 3;
    localparam int BIT_REVERSE = 4;
    // Times in tenths of microseconds for every entry, 125000 for 12.5 ms
    localparam longint DLY_US_X10 [8] = '{200, 125000, 250000, 500000, 1000000, 2000000,
                                         4000000, 16000000};
    localparam longint FLT_MS [4] = '{25, 50, 100, 200};
    localparam int DEGLITCH [4] = '{2, 4, 8, 16};
    localparam int CNT_W = 32;
    typedef enum logic [2:0] {PSQ_OFF, PSQ_UP, PSQ_ON, PSQ_DOWN, PSQ_RETRY, PSQ_LATCH} psq_state_t;
endpackage

// [verif/psq_supply_model.sv]
// Supplies behind the enables, reporting good after a lag, plus the ADC tick
`timescale 1ns/1ps
module psq_supply_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [11:0] en_out,
    input wire logic dead,
    input wire logic glitch,
    output logic [11:0] monitored_voltage_input,
    output logic conversion_done,
    output logic fault_raw
);
    logic [2:0] on_q;
    logic [1:0] tick;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            on_q <= 3'h0;
            tick <= 2'h0;
        end else begin
            on_q <= {on_q[1:0], |en_out};
            tick <= tick + 2'h1;
        end
    end
    assign monitored_voltage_input = {12{on_q[2] & ~dead}};
    assign conversion_done = &tick;
    assign fault_raw = glitch;
endmodule

// [verif/psq_slot_seq_properties.sv]
// Checker for register copies, power-down order and fault handling
`timescale 1ns/1ps
module psq_slot_seq_properties
    import psq_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic seq_enable,
    input wire logic [NUM_SLOTS-1:0] monitored_voltage_input,
    input wire logic conversion_done,
    input wire logic fault_raw,
    input wire logic [NUM_OUTS-1:0] en_out,
    input wire logic [3:0] tracking_pulldown_en,
    input wire logic [1:0] slew_select,
    input wire logic fault_active,
    input wire logic power_on
);
    logic [7:0] sh_tmo;
    logic [7:0] sh_rty;
    logic rev;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sh_tmo <= 8'h00;
            sh_rty <= 8'h00;
            rev <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_FLT_TMO) sh_tmo <= reg_wdata;
            if (reg_addr == ADDR_RETRY) sh_rty <= reg_wdata;
            if (reg_addr == ADDR_DLY_E) rev <= reg_wdata[BIT_REVERSE];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_drop_sim;
        !rev && power_on && $fell(seq_enable);
    endsequence
    sequence s_fault;
        $rose(fault_active);
    endsequence
    a_pd_copy: assert property (reg_wr && reg_addr == ADDR_FLT_TMO |-> ##2
        tracking_pulldown_en == sh_tmo[7:4]) else $error("pulldown copy wrong");
    a_slew_copy: assert property (reg_wr && reg_addr == ADDR_RETRY |-> ##2
        slew_select == sh_rty[5:4]) else $error("slew copy wrong");
    a_unmapped_zero: assert property (reg_rd && !(reg_addr inside
        {[ADDR_FLT_TMO:ADDR_DLY_E], [ADDR_ASSIGN_BASE:8'h63]}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_unused_bits: assert property (reg_rd && reg_addr == ADDR_DLY_E |=> reg_rdata[7:5] == 3'h0)
        else $error("unused bits read back");
    a_simul_down: assert property (s_drop_sim |-> ##2 en_out == '0)
        else $error("simultaneous power-down late");
    a_down_mono: assert property (!seq_enable && $past(!seq_enable) |->
        (en_out & ~$past(en_out)) == '0) else $error("enable rose in power-down");
    a_up_hold: assert property (seq_enable && $past(seq_enable) &&
        |($past(en_out) & ~en_out) |-> ##[0:1] fault_active) else $error("enable dropped");
    a_fault_off: assert property (s_fault |-> ##[0:1] en_out == '0)
        else $error("enables kept on fault");
    a_latch_hold: assert property (sh_rty[BIT_RECOVERY] && fault_active |=> fault_active)
        else $error("latch-off released");
endmodule
bind psq_slot_seq psq_slot_seq_properties i_props (.core_clk, .reset, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .seq_enable, .monitored_voltage_input,
    .conversion_done, .fault_raw, .en_out, .tracking_pulldown_en, .slew_select,
    .fault_active, .power_on);

// [verif/tb_top.sv]
// Random and corner tests of the slot sequencer against its supplies
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch %0t got %h exp %h", $time, a, b); end end
module tb_top;
    import psq_pkg::*;
    logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, seq_enable = 0, dead = 0, glitch = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, a, v, d;
    logic [11:0] en_out, monitored_voltage_input, m;
    logic [3:0] tracking_pulldown_en;
    logic [3:0] c [12];
    logic [1:0] slew_select, g;
    logic conversion_done, fault_raw, fault_active, power_on;
    int err_count = 0, compares = 0, tr[12], tf[12], sl[12], n, k;
    psq_slot_seq #(.US_DIV(1000)) i_dut (.core_clk, .reset, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .seq_enable, .monitored_voltage_input, .conversion_done,
        .fault_raw, .en_out, .tracking_pulldown_en, .slew_select, .fault_active, .power_on);
    psq_supply_model i_sup (.core_clk, .reset, .en_out, .dead, .glitch,
        .monitored_voltage_input, .conversion_done, .fault_raw);
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        err_count++;
        conclude();
    end
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] ad, logic [7:0] dt);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= dt;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] ad);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rst();
        @(posedge core_clk);
        reset <= 1'b1;
        seq_enable <= 1'b0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
    endtask
    function automatic int slot_of(logic [3:0] cd);
        return (cd != CODE_NONE && cd <= CODE_MAX) ? int'(cd) - 1 : 99;
    endfunction
    task automatic wait_on();
        for (n = 0; n < 3000 && power_on !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
            for (k = 0; k < 12; k++) if (en_out[k] && tr[k] < 0) tr[k] = n;
        end
    endtask
    task automatic t_seq(logic rv);
        for (k = 0; k < 12; k++) begin
            c[k] = (k == 0) ? 4'h1 : (k == 11) ? 4'hc : (k == 1) ? 4'hd : 4'($urandom);
            sl[k] = slot_of(c[k]);
            tr[k] = -1;
            tf[k] = -1;
            m[k] = sl[k] < 12;
        end
        for (k = 0; k < 6; k++) wr(ADDR_ASSIGN_BASE + 8'(k), {c[2*k+1], c[2*k]});
        for (k = 0; k < 4; k++) wr(ADDR_DLY_A + 8'(k), 8'h00);
        wr(ADDR_DLY_E, {3'h0, rv, 4'h0});
        seq_enable <= 1'b1;
        wait_on();
        `CHK(en_out, m)
        @(posedge core_clk);
        seq_enable <= 1'b0;
        for (n = 0; n < 3000 && en_out != 0; n++) begin
            @(posedge core_clk);
            #1;
            for (k = 0; k < 12; k++) if (!en_out[k] && tf[k] < 0) tf[k] = n;
        end
        for (k = 0; k < 12; k++) for (int j = 0; j < 12; j++) begin
            if (j != k && sl[k] <= sl[j] && sl[j] < 12) begin
                `CHK(sl[k] < sl[j] ? tr[k] < tr[j] : tr[k] == tr[j], 1'b1)
                `CHK(sl[k] < sl[j] && rv ? tf[k] > tf[j] : tf[k] == tf[j], 1'b1)
            end
        end
    endtask
    task automatic t_flt(logic lt);
        g = 2'($urandom);
        wr(ADDR_RETRY, {g, 2'h0, lt, 3'h0});
        seq_enable <= 1'b1;
        wait_on();
        @(posedge core_clk);
        glitch <= 1'b1;
        repeat (DEGLITCH[g] - 1) @(posedge core_clk iff conversion_done);
        glitch <= 1'b0;
        repeat (8) @(posedge core_clk);
        #1 `CHK(fault_active, 1'b0)
        @(posedge core_clk);
        glitch <= 1'b1;
        repeat (DEGLITCH[g]) @(posedge core_clk iff conversion_done);
        glitch <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1 `CHK({fault_active, en_out}, 13'h1000)
        repeat (200) @(posedge core_clk);
        #1 `CHK(fault_active, lt)
        wait_on();
        `CHK(power_on, !lt)
        rst();
    endtask
    initial begin
        k = $urandom(37666);
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        for (k = 0; k < 14; k++) begin
            a = (k < 7) ? ADDR_FLT_TMO + 8'(k) : (k < 13) ? ADDR_ASSIGN_BASE + 8'(k - 7) : 8'h55;
            v = 8'($urandom);
            wr(a, v);
            rd(a);
            `CHK(d, k == 13 ? 8'h00 : a == ADDR_DLY_E ? v & DLY_E_RW_MASK : v)
            if (k == 0) `CHK(tracking_pulldown_en, v[7:4])
            if (k == 1) `CHK(slew_select, v[5:4])
        end
        $display("register test done");
        rst();
        t_seq(1'b0);
        t_seq(1'b1);
        $display("sequence tests done");
        t_flt(1'b0);
        t_flt(1'b1);
        $display("fault tests done");
        g = 2'($urandom) & 2'h1;
        wr(ADDR_FLT_TMO, {6'h0, g});
        dead <= 1'b1;
        seq_enable <= 1'b1;
        for (n = 0; n < 60000 && fault_active !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        `CHK(n >= FLT_MS[g] * 250 && n < FLT_MS[g] * 250 + 40, 1'b1)
        $display("undervoltage test done");
        conclude();
    end
endmodule
